// file: cdt_pkg.sv
package cdt_pkg;

    // Bank size and bus widths
    localparam int unsigned num_timers = 8;
    localparam int unsigned data_w = 32;
    localparam int unsigned addr_w = 12;

    // Counter width of each timer, from 8 to 32 bits
    localparam int unsigned timer_width [num_timers] = '{32, 32, 16, 16, 8, 8, 24, 32};

    // Build options
    localparam bit enhanced_mode_option = 1'b1;
    localparam bit irq_bus_sync_option = 1'b0;
    localparam bit irq_polarity_option = 1'b1;

    // Address layout: one 32-byte block per timer, then the global registers
    localparam logic [addr_w-1:0] timer_block_mask = 12'h01f;
    localparam int unsigned timer_index_lsb = 5;
    localparam logic [addr_w-1:0] global_base = 12'h100;

    // Offsets inside a timer block
    localparam logic [addr_w-1:0] off_reload_value_n = 12'h000;
    localparam logic [addr_w-1:0] off_counter_readback_n = 12'h004;
    localparam logic [addr_w-1:0] off_per_timer_control_n = 12'h008;
    localparam logic [addr_w-1:0] off_irq_ack_n = 12'h00c;
    localparam logic [addr_w-1:0] off_irq_state_n = 12'h010;
    localparam logic [addr_w-1:0] off_high_reload_value_n = 12'h014;

    // Global registers
    localparam logic [addr_w-1:0] addr_irq_state_all = 12'h100;
    localparam logic [addr_w-1:0] addr_irq_ack_all = 12'h104;
    localparam logic [addr_w-1:0] addr_raw_irq_all = 12'h108;

    // Control register fields
    localparam int unsigned ctl_enable_bit = 0;
    localparam int unsigned ctl_mode_bit = 1;
    localparam int unsigned ctl_mask_bit = 2;
    localparam int unsigned ctl_width = 3;

    // Reset values
    localparam logic [ctl_width-1:0] ctl_reset = 3'h0;
    localparam logic [data_w-1:0] reload_reset = 32'h0000_0000;
    localparam logic [data_w-1:0] word_zero = 32'h0000_0000;

    // Decoded register kinds
    typedef enum logic [3:0] {
        cdt_reg_none,
        cdt_reg_reload,
        cdt_reg_readback,
        cdt_reg_control,
        cdt_reg_ack,
        cdt_reg_state,
        cdt_reg_high_reload,
        cdt_reg_state_all,
        cdt_reg_ack_all,
        cdt_reg_raw_all
    } cdt_reg_t;

endpackage : cdt_pkg

// file: cdt_timer_bank.sv
`timescale 1ns/10ps
`default_nettype none

// Contract
// - Control bit 0 enables or disables timer
// - Enabled timer decrements on each count edge
// - First count edge after enable loads reload value
// - Disable resets counter, toggle, count state
// - Readback is zero while disabled, else live
// - Per-timer counter width, 8 to 32 bits
// - Reload accepted in parts by byte lanes
// - User mode reloads reload value at zero
// - Free mode reloads all ones at zero
// - Enhanced user mode alternates both reload values
// - Internal interrupt on zero to reload wrap
// - Disabled timer: no interrupts, pending cleared
// - Enhanced unsynced: interrupt straight from count side
// - That interrupt persists until ack or disable
// - Per-timer ack read clears only that timer
// - Global ack read clears all, penable low
// - Set beats clear when ack meets interrupt
// - State registers read without clearing anything
// - Control bit 2 masks timer interrupt
// - All masked means combined flag masked
// - Global flag set when any timer interrupts
// - One polarity option for all interrupt outputs
// - Counter-active bus output per timer
// - Non-enhanced sets interrupt by edge detect
// - PWM toggle low reload+1, high high+1
module cdt_timer_bank (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cdt_pkg::addr_w-1:0] paddr,
    input wire logic [cdt_pkg::data_w-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [cdt_pkg::data_w-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Timer count clocks, sampled as synchronous inputs
    input wire logic [cdt_pkg::num_timers-1:0] timer_clk,
    // Timer outputs
    output logic [cdt_pkg::num_timers-1:0] counter_active,
    output logic [cdt_pkg::num_timers-1:0] toggle,
    output logic [cdt_pkg::num_timers-1:0] timer_irq,
    output logic timer_irq_flag
);

    localparam int unsigned nt = cdt_pkg::num_timers;
    localparam int unsigned dw = cdt_pkg::data_w;

    // All-ones value of the given timer's width
    function automatic logic [dw-1:0] width_mask(input int unsigned idx);
        logic [dw-1:0] m;
        m = '1;
        width_mask = m >> (dw - cdt_pkg::timer_width[idx]);
    endfunction : width_mask

    // Byte-lane merge of a write into a stored word
    function automatic logic [dw-1:0] lane_merge(input logic [dw-1:0] old, input logic [dw-1:0] wd,
                                                 input logic [3:0] strb);
        logic [dw-1:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        lane_merge = r;
    endfunction : lane_merge

    // Register kind of an address
    function automatic cdt_pkg::cdt_reg_t decode(input logic [cdt_pkg::addr_w-1:0] a);
        logic [cdt_pkg::addr_w-1:0] off;
        off = a & cdt_pkg::timer_block_mask;
        decode = cdt_pkg::cdt_reg_none;
        if (a < cdt_pkg::global_base) begin
            case (off)
                cdt_pkg::off_reload_value_n: decode = cdt_pkg::cdt_reg_reload;
                cdt_pkg::off_counter_readback_n: decode = cdt_pkg::cdt_reg_readback;
                cdt_pkg::off_per_timer_control_n: decode = cdt_pkg::cdt_reg_control;
                cdt_pkg::off_irq_ack_n: decode = cdt_pkg::cdt_reg_ack;
                cdt_pkg::off_irq_state_n: decode = cdt_pkg::cdt_reg_state;
                cdt_pkg::off_high_reload_value_n: begin
                    if (cdt_pkg::enhanced_mode_option) begin
                        decode = cdt_pkg::cdt_reg_high_reload;
                    end
                end
                default: decode = cdt_pkg::cdt_reg_none;
            endcase
        end else begin
            case (a)
                cdt_pkg::addr_irq_state_all: decode = cdt_pkg::cdt_reg_state_all;
                cdt_pkg::addr_irq_ack_all: decode = cdt_pkg::cdt_reg_ack_all;
                cdt_pkg::addr_raw_irq_all: decode = cdt_pkg::cdt_reg_raw_all;
                default: decode = cdt_pkg::cdt_reg_none;
            endcase
        end
    endfunction : decode

    // Software-visible state
    logic [cdt_pkg::ctl_width-1:0] per_timer_control_n [nt];
    logic [dw-1:0] reload_value_n [nt];
    logic [dw-1:0] high_reload_value_n [nt];

    // Count-side state
    logic [dw-1:0] count [nt];
    logic [nt-1:0] enable_seen;
    logic [nt-1:0] count_clk_q;
    logic [nt-1:0] raw_irq;
    logic [nt-1:0] raw_irq_q;
    logic [nt-1:0] pending;

    // Bus decode
    cdt_pkg::cdt_reg_t sel_kind;
    logic [2:0] sel_timer;
    logic setup_phase;
    logic write_done;
    logic [nt-1:0] enabled;
    logic [nt-1:0] masked;
    logic [dw-1:0] ctl_merged;

    always_comb begin
        sel_kind = decode(paddr);
        sel_timer = paddr[cdt_pkg::timer_index_lsb +: 3];
        setup_phase = psel & ~penable;
        write_done = psel & penable & pready & pwrite;
        // Control word merged by lanes, then cut to its three live bits
        ctl_merged = lane_merge({29'h0, per_timer_control_n[sel_timer]}, pwdata, pstrb);
        for (int i = 0; i < nt; i++) begin
            enabled[i] = per_timer_control_n[i][cdt_pkg::ctl_enable_bit];
            masked[i] = per_timer_control_n[i][cdt_pkg::ctl_mask_bit];
        end
    end

    // APB handshake: one wait-free access, answer registered at setup
    always_ff @(posedge clk) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup_phase;
            pslverr <= setup_phase && (sel_kind == cdt_pkg::cdt_reg_none);
        end
    end

    // Register writes take effect at the completing edge
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < nt; i++) begin
                per_timer_control_n[i] <= cdt_pkg::ctl_reset;
                reload_value_n[i] <= cdt_pkg::reload_reset;
                high_reload_value_n[i] <= cdt_pkg::reload_reset;
            end
        end else if (write_done) begin
            case (sel_kind)
                cdt_pkg::cdt_reg_control: begin
                    // Enable, mode and mask written together
                    per_timer_control_n[sel_timer] <= ctl_merged[cdt_pkg::ctl_width-1:0];
                end
                cdt_pkg::cdt_reg_reload: begin
                    // Narrow masters fill the word one lane at a time
                    reload_value_n[sel_timer] <= lane_merge(reload_value_n[sel_timer], pwdata, pstrb)
                                                 & width_mask(32'(sel_timer));
                end
                cdt_pkg::cdt_reg_high_reload: begin
                    high_reload_value_n[sel_timer] <= lane_merge(high_reload_value_n[sel_timer], pwdata, pstrb)
                                                      & width_mask(32'(sel_timer));
                end
                default: begin
                end
            endcase
        end
    end

    // Read data, registered in the setup cycle so no side effect waits on penable
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= cdt_pkg::word_zero;
        end else if (setup_phase && !pwrite) begin
            case (sel_kind)
                cdt_pkg::cdt_reg_reload: prdata <= reload_value_n[sel_timer];
                cdt_pkg::cdt_reg_high_reload: prdata <= high_reload_value_n[sel_timer];
                cdt_pkg::cdt_reg_readback: begin
                    prdata <= enabled[sel_timer] ? count[sel_timer] : cdt_pkg::word_zero;
                end
                cdt_pkg::cdt_reg_control: prdata <= {29'h0, per_timer_control_n[sel_timer]};
                cdt_pkg::cdt_reg_ack: prdata <= {31'h0, pending[sel_timer] & ~masked[sel_timer]};
                cdt_pkg::cdt_reg_state: prdata <= {31'h0, pending[sel_timer] & ~masked[sel_timer]};
                cdt_pkg::cdt_reg_state_all: prdata <= {24'h0, pending & ~masked};
                cdt_pkg::cdt_reg_ack_all: prdata <= {24'h0, pending & ~masked};
                cdt_pkg::cdt_reg_raw_all: prdata <= {24'h0, pending};
                default: prdata <= cdt_pkg::word_zero;
            endcase
        end
    end

    // Count clock edge detection; inputs are already synchronous
    always_ff @(posedge clk) begin
        if (rst) begin
            count_clk_q <= '0;
        end else begin
            count_clk_q <= timer_clk;
        end
    end

    // Counters
    always_ff @(posedge clk) begin
        for (int i = 0; i < nt; i++) begin
            if (rst || !enabled[i]) begin
                // Disable clears count, enable_seen, toggle and raw_irq at once
                count[i] <= cdt_pkg::word_zero;
                enable_seen[i] <= 1'b0;
                toggle[i] <= 1'b0;
                raw_irq[i] <= 1'b0;
            end else if (timer_clk[i] && !count_clk_q[i]) begin
                enable_seen[i] <= 1'b1;
                if (!enable_seen[i]) begin
                    count[i] <= reload_value_n[i];
                    raw_irq[i] <= 1'b0;
                end else if (count[i] == cdt_pkg::word_zero) begin
                    raw_irq[i] <= 1'b1;
                    toggle[i] <= ~toggle[i];
                    if (!per_timer_control_n[i][cdt_pkg::ctl_mode_bit]) begin
                        count[i] <= width_mask(i);
                    end else if (cdt_pkg::enhanced_mode_option && !toggle[i]) begin
                        // Toggle about to rise: high phase counts from the second value
                        count[i] <= high_reload_value_n[i];
                    end else begin
                        count[i] <= reload_value_n[i];
                    end
                end else begin
                    count[i] <= count[i] - 32'h0000_0001;
                    raw_irq[i] <= 1'b0;
                end
            end
        end
    end

    // Pending interrupts
    always_ff @(posedge clk) begin
        if (rst) begin
            raw_irq_q <= '0;
        end else begin
            raw_irq_q <= raw_irq;
        end
    end

    logic [nt-1:0] irq_set;
    logic [nt-1:0] irq_clear;

    always_comb begin
        for (int i = 0; i < nt; i++) begin
            if (cdt_pkg::enhanced_mode_option && !cdt_pkg::irq_bus_sync_option) begin
                irq_set[i] = raw_irq[i];
            end else begin
                irq_set[i] = raw_irq[i] & ~raw_irq_q[i];
            end
            // Acks act in the setup cycle, while penable is still low
            irq_clear[i] = setup_phase && !pwrite
                           && ((sel_kind == cdt_pkg::cdt_reg_ack && sel_timer == 3'(i))
                               || sel_kind == cdt_pkg::cdt_reg_ack_all);
        end
    end

    always_ff @(posedge clk) begin
        for (int i = 0; i < nt; i++) begin
            if (rst || !enabled[i]) begin
                pending[i] <= 1'b0;
            end else if (irq_set[i] || raw_irq[i]) begin
                // A clear that meets a live internal interrupt is lost
                pending[i] <= pending[i] | irq_set[i];
            end else if (irq_clear[i]) begin
                pending[i] <= 1'b0;
            end
        end
    end

    // Outputs, all from flops
    always_ff @(posedge clk) begin
        if (rst) begin
            counter_active <= '0;
            timer_irq <= {nt{~cdt_pkg::irq_polarity_option}};
            timer_irq_flag <= ~cdt_pkg::irq_polarity_option;
        end else begin
            counter_active <= enabled;
            for (int i = 0; i < nt; i++) begin
                timer_irq[i] <= (pending[i] & ~masked[i]) ^ ~cdt_pkg::irq_polarity_option;
            end
            // Masked timers drop out, so an all-masked bank never flags
            timer_irq_flag <= (|(pending & ~masked)) ^ ~cdt_pkg::irq_polarity_option;
        end
    end

endmodule : cdt_timer_bank

`default_nettype wire

// file: cdt_timer_bank_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module cdt_timer_bank_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cdt_pkg::addr_w-1:0] paddr,
    input wire logic [cdt_pkg::data_w-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Timer outputs
    input wire logic [cdt_pkg::num_timers-1:0] counter_active,
    input wire logic [cdt_pkg::num_timers-1:0] toggle,
    input wire logic [cdt_pkg::num_timers-1:0] timer_irq,
    input wire logic timer_irq_flag
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // Unaligned addresses are not judged here
    function automatic logic unmapped(input logic [11:0] a);
        return (a < 12'h100) ? (a[4:0] > 5'h14) : (a > 12'h108);
    endfunction : unmapped
    a_setup_answer: assert property (psel && !penable |=> pready) else $error("no ready after setup");
    a_ready_single: assert property (pready |=> !pready) else $error("ready held too long");
    a_error_map: assert property (pready |-> pslverr == unmapped(paddr)) else $error("bad slave error");
    a_error_data: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("error read data");
    a_idle_irq: assert property ((timer_irq & ~counter_active & ~$past(counter_active)
        & ~$past(counter_active, 2)) == 8'h00) else $error("irq on idle timer");
    a_idle_toggle: assert property ((toggle & ~counter_active & ~$past(counter_active)) == 8'h00)
        else $error("toggle on idle timer");
    a_flag_any: assert property (|timer_irq |-> ##[0:1] timer_irq_flag) else $error("flag missing");
    a_flag_idle: assert property (timer_irq_flag |-> (|timer_irq) || (|$past(timer_irq)))
        else $error("flag without irq");
    a_reset_quiet: assert property ($fell(rst) |-> !pready && !timer_irq_flag && toggle == 8'h00
        && timer_irq == 8'h00) else $error("outputs busy after reset");
    c_irq: cover property ($rose(timer_irq_flag));
    c_error: cover property (pready && pslverr);
    c_toggle: cover property ($fell(toggle[2]));
endmodule : cdt_timer_bank_chk
bind cdt_timer_bank cdt_timer_bank_chk u_chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .counter_active(counter_active), .toggle(toggle), .timer_irq(timer_irq), .timer_irq_flag(timer_irq_flag));
`default_nettype wire

// file: cdt_apb_master.sv
`timescale 1ns/10ps
`default_nettype none
module cdt_apb_master (
    // Clock
    input wire logic clk,
    // Request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [cdt_pkg::addr_w-1:0] paddr,
    output logic [cdt_pkg::data_w-1:0] pwdata,
    output logic [3:0] pstrb,
    // Answer
    input wire logic pready
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
    end
    // Read data is taken by the bench monitor at the ready edge
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        // No limit here: the bench watchdog ends a hung wait
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : cdt_apb_master
`default_nettype wire

// file: tb_countdown_timer_bank.sv
`timescale 1ns/10ps
`default_nettype none
module tb_countdown_timer_bank;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] tclk = 8'h00;
    logic [1:0] div = 2'h0;
    logic psel, penable, pwrite, pready, pslverr, flag;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0] pstrb;
    logic [7:0] act, tgl, irq;
    logic [64:0] exp_q[$];
    logic [64:0] e;
    int n_mismatch = 0;
    int cmp_count = 0;
    int k;
    logic [31:0] lfsr = 32'h35cad58b;
    always #12.5 clk = ~clk;
    // Count clocks at a quarter of the bus rate
    always @(posedge clk) begin
        div <= div + 2'h1;
        tclk <= {8{div[1]}};
    end
    cdt_apb_master m (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .pready(pready));
    cdt_timer_bank dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_clk(tclk), .counter_active(act), .toggle(tgl), .timer_irq(irq),
        .timer_irq_flag(flag));
    function automatic logic [31:0] lfsr_step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_step
    function automatic logic [11:0] ta(input int n, input logic [11:0] off);
        return 12'(n * 32) | off;
    endfunction : ta
    task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, seen, exp);
        end
    endtask : check
    task test_done;
        $display("%0d comparisons, %0d mismatches", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : test_done
    task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        m.xfer(1'b1, a, d, s);
    endtask : wr
    task rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] msk, input logic err);
        exp_q.push_back({msk, err, d});
        m.xfer(1'b0, a, 32'h0, 4'hf);
    endtask : rd
    // Waits while the given level holds, counting the cycles
    task hold(input int n, input logic v);
        k = 0;
        while (tgl[n] === v && k < 400) begin
            @(posedge clk);
            k++;
        end
    endtask : hold
    task wait_irq(input int n);
        k = 0;
        while (irq[n] !== 1'b1 && k < 3000) begin
            @(posedge clk);
            k++;
        end
    endtask : wait_irq
    always @(posedge clk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 65'h0;
            check(prdata & e[64:33], e[31:0], "read data");
            check({31'h0, pslverr}, {31'h0, e[32]}, "slave error");
        end
    end
    initial begin
        #(25 * 20000);
        n_mismatch++;
        test_done();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(ta(0, cdt_pkg::off_per_timer_control_n), 32'h0, 32'hffffffff, 1'b0);
        rd(ta(0, cdt_pkg::off_counter_readback_n), 32'h0, 32'hffffffff, 1'b0);
        rd(ta(0, 12'h018), 32'h0, 32'hffffffff, 1'b1);
        rd(12'h10c, 32'h0, 32'hffffffff, 1'b1);
        $display("test reset done");
        lfsr = lfsr_step(lfsr);
        r = lfsr;
        wr(ta(2, cdt_pkg::off_reload_value_n), r, 4'h1);
        wr(ta(2, cdt_pkg::off_reload_value_n), ~r, 4'h2);
        rd(ta(2, cdt_pkg::off_reload_value_n), {16'h0, ~r[15:8], r[7:0]}, 32'hffffffff, 1'b0);
        $display("test lanes done");
        wr(ta(2, cdt_pkg::off_reload_value_n), 32'd9, 4'hf);
        wr(ta(2, cdt_pkg::off_high_reload_value_n), 32'd19, 4'hf);
        wr(ta(2, cdt_pkg::off_per_timer_control_n), 32'h3, 4'hf);
        @(posedge clk);
        #1 check({31'h0, act[2]}, 32'h1, "active");
        hold(2, 1'b0);
        hold(2, 1'b1);
        check(k, 80, "high phase");
        hold(2, 1'b0);
        check(k, 40, "low phase");
        wait_irq(2);
        repeat (6) @(posedge clk);
        rd(ta(2, cdt_pkg::off_irq_state_n), 32'h1, 32'h1, 1'b0);
        rd(ta(2, cdt_pkg::off_irq_ack_n), 32'h1, 32'h1, 1'b0);
        @(posedge clk);
        #1 check({31'h0, irq[2]}, 32'h0, "ack one");
        wait_irq(2);
        wr(ta(2, cdt_pkg::off_per_timer_control_n), 32'h7, 4'hf);
        repeat (130) @(posedge clk);
        #1 check({23'h0, flag, irq}, 32'h0, "masked");
        rd(cdt_pkg::addr_raw_irq_all, 32'h4, 32'hff, 1'b0);
        rd(cdt_pkg::addr_irq_state_all, 32'h0, 32'hff, 1'b0);
        wr(ta(2, cdt_pkg::off_per_timer_control_n), 32'h0, 4'hf);
        repeat (3) @(posedge clk);
        #1 check({29'h0, act[2], tgl[2], irq[2]}, 32'h0, "disabled");
        rd(ta(2, cdt_pkg::off_counter_readback_n), 32'h0, 32'hffffffff, 1'b0);
        $display("test user mode done");
        wr(ta(4, cdt_pkg::off_reload_value_n), 32'd5, 4'hf);
        wr(ta(4, cdt_pkg::off_per_timer_control_n), 32'h1, 4'hf);
        wait_irq(4);
        check({31'h0, flag}, 32'h1, "flag");
        repeat (8) @(posedge clk);
        rd(ta(4, cdt_pkg::off_counter_readback_n), 32'hf0, 32'hfffffff0, 1'b0);
        rd(cdt_pkg::addr_irq_ack_all, 32'h0, 32'h0, 1'b0);
        @(posedge clk);
        #1 check({23'h0, flag, irq}, 32'h0, "ack all");
        $display("test free mode done");
        test_done();
    end
endmodule : tb_countdown_timer_bank
`default_nettype wire
